// [hdl/acs_pkg.sv]
// Shared constants and types for the calibration sequencer and its host controller
// Function
// - Calibration starts on any nonzero mode write, anytime
// - Mode 0,1 runs self zero then full
// - Self zero step shorts inputs, selected gain
// - Self full step converts reference over gain
// - Self calibration takes three plus three periods
// - Mode field returns to 0,0 when done
// - Ready line high from start until word
// - Self calibration ready after about nine periods
// - Ready rise may lag one modulator cycle
// - Host ignores ready one modulator cycle
// - Bipolar self zero point means midscale
// - Mode 1,0 runs system zero-scale step
// - System step three periods, ready after four
// - Mode 1,1 runs system full-scale step
// - Host runs system zero before full
// - Calibration input held steady during step
// - Zero and full results stored separately
// - Unipolar spans endpoints, bipolar midscale upward
// - Lone offset or gain recalibration allowed
// - 33-bit slope, 16-bit corrected result
// - Host flags recalibration after setting changes
package acs_pkg;

  localparam int          RAW_W             = 24;
  localparam int          OUT_W             = 16;
  localparam int          SLOPE_W           = 33;
  localparam int          SPAN_W            = RAW_W + 1;
  localparam int          DIV_ITER          = 33;
  localparam int          MOD_CYC_CLKS      = 128;
  localparam logic [1:0]  CAL_STEP_PERIODS  = 2'h3;
  localparam logic [1:0]  CONV_SELF_PERIODS = 2'h3;
  localparam logic [1:0]  CONV_SYS_PERIODS  = 2'h1;

  localparam logic [1:0]  MODE_NORM     = 2'h0;
  localparam logic [1:0]  MODE_SELF     = 2'h1;
  localparam logic [1:0]  MODE_SYS_ZERO = 2'h2;
  localparam logic [1:0]  MODE_SYS_FULL = 2'h3;

  localparam logic [1:0]  SEL_EXT   = 2'h0;
  localparam logic [1:0]  SEL_SHORT = 2'h1;
  localparam logic [1:0]  SEL_REF   = 2'h2;

  localparam logic [RAW_W-1:0]   ZERO_COEF_RST = 24'h00_0000;
  localparam logic [RAW_W-1:0]   FULL_COEF_RST = 24'hFF_FFFF;
  localparam logic [SLOPE_W-1:0] SLOPE_RST     = 33'h0_0000_0100;
  localparam logic [OUT_W-1:0]   OUT_MAX       = 16'hFFFF;
  localparam logic [OUT_W-1:0]   OUT_MID       = 16'h8000;

  // Avalon-MM byte addresses of the host registers
  localparam int          AVS_ADDR_W  = 4;
  localparam logic [3:0]  REG_CTRL    = 4'h0;
  localparam logic [3:0]  REG_STATUS  = 4'h4;
  localparam logic [3:0]  REG_DATA    = 4'h8;

  localparam int CTRL_MODE_LSB   = 0;
  localparam int CTRL_GAIN_LSB   = 2;
  localparam int CTRL_BIP_BIT    = 4;
  localparam int STAT_MODE_LSB   = 0;
  localparam int STAT_READY_BIT  = 2;
  localparam int STAT_BLANK_BIT  = 3;
  localparam int STAT_ORDER_BIT  = 4;
  localparam int STAT_RECAL_BIT  = 5;

  localparam logic [7:0]  BLANK_LOAD = 8'h80;

  typedef enum {ST_NORM, ST_ZERO, ST_FULL, ST_DIV, ST_CONV} acs_state_e;

endpackage

// [hdl/acs_link_if.sv]
// Setup-write and result link between host controller and calibration sequencer
`timescale 1ns/1ps
`default_nettype none
interface acs_link_if;
  logic        setup_wr;
  logic        cal_mode_hi;
  logic        cal_mode_lo;
  logic        gain_sel_hi;
  logic        gain_sel_lo;
  logic        bipolar;
  logic [1:0]  mode_rb;
  logic        result_valid_n;
  logic [15:0] result_data;

  modport dev (
    input  setup_wr, cal_mode_hi, cal_mode_lo, gain_sel_hi, gain_sel_lo, bipolar,
    output mode_rb, result_valid_n, result_data
  );
  modport host (
    output setup_wr, cal_mode_hi, cal_mode_lo, gain_sel_hi, gain_sel_lo, bipolar,
    input  mode_rb, result_valid_n, result_data
  );
endinterface
`default_nettype wire

// [hdl/acs_device.sv]
// Calibration sequencer of the converter: steps, coefficients and corrected output
//
// Decided for this implementation: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module acs_device
  import acs_pkg::*;
(
  input  wire logic             CLK_SYS,
  input  wire logic             RESETN,
  acs_link_if.dev               LINK,
  input  wire logic [RAW_W-1:0] FILT_DATA,
  input  wire logic             FILT_STB,
  output logic [1:0]            INPUT_SEL,
  output logic [1:0]            PGA_GAIN,
  output logic                  BIPOLAR,
  output logic [RAW_W-1:0]      ZERO_COEF,
  output logic [RAW_W-1:0]      FULL_COEF
);

  acs_state_e             state_reg, state_next;
  logic [1:0]             mode_reg;
  logic                   self_reg;
  logic [1:0]             gain_reg;
  logic                   bip_reg;
  logic [1:0]             per_cnt_reg;
  logic [6:0]             mod_cnt_reg;
  logic                   raise_pend_reg;
  logic                   valid_n_reg;
  logic [OUT_W-1:0]       data_reg;
  logic [RAW_W-1:0]       zero_reg;
  logic [RAW_W-1:0]       full_reg;
  logic [SLOPE_W-1:0]     slope_reg;
  logic [SLOPE_W-1:0]     quot_reg;
  logic [SPAN_W:0]        rem_reg;
  logic [5:0]             div_cnt_reg;

  wire [1:0]  mode_in   = {LINK.cal_mode_hi, LINK.cal_mode_lo};
  wire        cal_cmd   = LINK.setup_wr && (mode_in != MODE_NORM);
  wire        abort_cmd = LINK.setup_wr && (mode_in == MODE_NORM);
  wire        mod_tick  = (mod_cnt_reg == 7'(MOD_CYC_CLKS - 1));

  wire [1:0]  per_need  = (state_reg == ST_CONV) ?
                          (self_reg ? CONV_SELF_PERIODS : CONV_SYS_PERIODS) :
                          CAL_STEP_PERIODS;
  wire        stb_last  = FILT_STB && (per_cnt_reg == per_need - 2'h1);
  wire        zero_done = (state_reg == ST_ZERO) && stb_last && !LINK.setup_wr;
  wire        full_done = (state_reg == ST_FULL) && stb_last && !LINK.setup_wr;
  wire        step_end  = full_done || (zero_done && !self_reg);
  wire        div_last  = (state_reg == ST_DIV) && (div_cnt_reg == 6'(DIV_ITER - 1));
  wire        div_start = (state_next == ST_DIV) && (state_reg != ST_DIV);

  // Span between the two points; a non-positive span is forced to one count
  wire [SPAN_W-1:0] span_raw = {1'b0, full_reg} - {1'b0, zero_reg};
  wire              span_ok  = !span_raw[SPAN_W-1] && (span_raw != '0);
  wire [SPAN_W-1:0] span     = span_ok ? span_raw : 25'h000_0001;

  // Restoring division of two to the 32nd by the span, one quotient bit a cycle
  wire [SPAN_W:0]   rem_sh   = {rem_reg[SPAN_W-1:0], (div_cnt_reg == 6'h00)};
  wire              rem_ge   = (rem_sh >= {1'b0, span});
  wire [SPAN_W:0]   rem_nx   = rem_ge ? (rem_sh - {1'b0, span}) : rem_sh;
  wire [SLOPE_W-1:0] quot_nx = {quot_reg[SLOPE_W-2:0], rem_ge};

  // Correction: offset removed, scaled by the 33-bit slope
  wire signed [SPAN_W-1:0]  diff  = $signed({1'b0, FILT_DATA}) - $signed({1'b0, zero_reg});
  wire signed [SLOPE_W:0]   slope_s = $signed({1'b0, slope_reg});
  wire signed [58:0]        prod  = 59'(diff * slope_s);
  wire signed [58:0]        uni   = prod >>> 16;
  wire signed [58:0]        bip   = (prod >>> 17) + 59'sh000_0000_0000_8000;
  wire signed [58:0]        scaled = bip_reg ? bip : uni;
  wire [OUT_W-1:0]          corrected = scaled[58] ? '0 :
                                        (scaled > 59'sh000_0000_0000_FFFF) ? OUT_MAX :
                                        scaled[OUT_W-1:0];

  wire word_done = !LINK.setup_wr && FILT_STB &&
                   ((state_reg == ST_NORM) || ((state_reg == ST_CONV) && stb_last));

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_NORM: state_next = ST_NORM;
      ST_ZERO: if (stb_last) state_next = self_reg ? ST_FULL : ST_DIV;
      ST_FULL: if (stb_last) state_next = ST_DIV;
      ST_DIV:  if (div_last) state_next = ST_CONV;
      ST_CONV: if (stb_last) state_next = ST_NORM;
      default: state_next = ST_NORM;
    endcase
    if (cal_cmd) begin
      state_next = (mode_in == MODE_SYS_FULL) ? ST_FULL : ST_ZERO;
    end else if (abort_cmd) begin
      state_next = ST_NORM;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      state_reg <= ST_NORM;
      mode_reg  <= MODE_NORM;
      self_reg  <= 1'b0;
      gain_reg  <= 2'h0;
      bip_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (LINK.setup_wr) begin
        mode_reg <= mode_in;
        gain_reg <= {LINK.gain_sel_hi, LINK.gain_sel_lo};
        bip_reg  <= LINK.bipolar;
      end else if (step_end) begin
        mode_reg <= MODE_NORM;
      end
      if (cal_cmd) begin
        self_reg <= (mode_in == MODE_SELF);
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      per_cnt_reg <= 2'h0;
      mod_cnt_reg <= 7'h00;
    end else begin
      mod_cnt_reg <= mod_cnt_reg + 7'h01;
      if (cal_cmd || abort_cmd || (state_next != state_reg)) begin
        per_cnt_reg <= 2'h0;
      end else if (FILT_STB && (state_reg != ST_NORM) && (state_reg != ST_DIV)) begin
        per_cnt_reg <= per_cnt_reg + 2'h1;
      end
    end
  end

  // Ready goes high at the next modulator tick after a calibration command
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      raise_pend_reg <= 1'b0;
      valid_n_reg    <= 1'b1;
      data_reg       <= '0;
    end else begin
      if (cal_cmd) begin
        raise_pend_reg <= 1'b1;
      end else if (mod_tick) begin
        raise_pend_reg <= 1'b0;
      end
      if (raise_pend_reg && mod_tick) begin
        valid_n_reg <= 1'b1;
      end else if (word_done && !raise_pend_reg) begin
        valid_n_reg <= 1'b0;
      end
      if (word_done) begin
        data_reg <= corrected;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      zero_reg <= ZERO_COEF_RST;
      full_reg <= FULL_COEF_RST;
    end else begin
      if (zero_done) begin
        zero_reg <= FILT_DATA;
      end
      if (full_done) begin
        full_reg <= FILT_DATA;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      rem_reg     <= '0;
      quot_reg    <= '0;
      div_cnt_reg <= 6'h00;
      slope_reg   <= SLOPE_RST;
    end else if (div_start) begin
      rem_reg     <= '0;
      quot_reg    <= '0;
      div_cnt_reg <= 6'h00;
    end else if (state_reg == ST_DIV) begin
      rem_reg     <= rem_nx;
      quot_reg    <= quot_nx;
      div_cnt_reg <= div_cnt_reg + 6'h01;
      if (div_last) begin
        slope_reg <= quot_nx;
      end
    end
  end

  // Self steps pick the shorted pair, then the reference over gain
  assign INPUT_SEL = !self_reg ? SEL_EXT :
                     (state_reg == ST_ZERO) ? SEL_SHORT :
                     (state_reg == ST_FULL) ? SEL_REF : SEL_EXT;
  assign PGA_GAIN  = gain_reg;
  assign BIPOLAR   = bip_reg;
  assign ZERO_COEF = zero_reg;
  assign FULL_COEF = full_reg;

  assign LINK.mode_rb        = mode_reg;
  assign LINK.result_valid_n = valid_n_reg;
  assign LINK.result_data    = data_reg;

endmodule
`default_nettype wire

// [hdl/acs_host.sv]
// Host controller: Avalon-MM registers driving the sequencer's setup link
`timescale 1ns/1ps
`default_nettype none
module acs_host
  import acs_pkg::*;
(
  input  wire logic                  CLK_SYS,
  input  wire logic                  RESETN,
  input  wire logic [AVS_ADDR_W-1:0] AVS_ADDRESS,
  input  wire logic                  AVS_READ,
  input  wire logic                  AVS_WRITE,
  input  wire logic [3:0]            AVS_BYTEENABLE,
  input  wire logic [31:0]           AVS_WRITEDATA,
  output logic [31:0]                AVS_READDATA,
  output logic                       AVS_WAITREQUEST,
  output logic                       CAL_HOLD,
  acs_link_if.host                   LINK
);

  logic        ack_reg;
  logic [31:0] rdata_reg;
  logic        wr_reg;
  logic [1:0]  mode_reg;
  logic [1:0]  gain_reg;
  logic        bip_reg;
  logic [7:0]  blank_reg;
  logic        zero_done_reg;
  logic        order_err_reg;
  logic        recal_reg;
  logic        hold_reg;

  wire        req      = AVS_READ || AVS_WRITE;
  wire        wr_go    = AVS_WRITE && ack_reg && AVS_BYTEENABLE[0];
  wire        ctrl_wr  = wr_go && (AVS_ADDRESS == REG_CTRL);
  wire        stat_wr  = wr_go && (AVS_ADDRESS == REG_STATUS);
  wire [1:0]  mode_w   = AVS_WRITEDATA[CTRL_MODE_LSB +: 2];
  wire [1:0]  gain_w   = AVS_WRITEDATA[CTRL_GAIN_LSB +: 2];
  wire        bip_w    = AVS_WRITEDATA[CTRL_BIP_BIT];
  wire        bad_ord  = ctrl_wr && (mode_w == MODE_SYS_FULL) && !zero_done_reg;
  wire        fwd      = ctrl_wr && !bad_ord;
  wire        cal_go   = fwd && (mode_w != MODE_NORM);
  wire        set_chg  = fwd && ((gain_w != gain_reg) || (bip_w != bip_reg));
  wire        blanking = (blank_reg != 8'h00);
  wire        ready    = !LINK.result_valid_n && !blanking;

  wire [31:0] status_word = {26'h000_0000, recal_reg, order_err_reg, blanking, ready,
                             LINK.mode_rb};
  wire [31:0] rd_mux = (AVS_ADDRESS == REG_CTRL)   ? {27'h000_0000, bip_reg, gain_reg,
                                                      mode_reg} :
                       (AVS_ADDRESS == REG_STATUS) ? status_word :
                       (AVS_ADDRESS == REG_DATA)   ? {16'h0000, LINK.result_data} :
                       32'h0000_0000;

  // One wait state on every access
  assign AVS_WAITREQUEST = req && !ack_reg;

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req && !ack_reg;
      if (AVS_READ && !ack_reg) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      wr_reg   <= 1'b0;
      mode_reg <= MODE_NORM;
      gain_reg <= 2'h0;
      bip_reg  <= 1'b0;
    end else begin
      wr_reg <= fwd;
      if (fwd) begin
        mode_reg <= mode_w;
        gain_reg <= gain_w;
        bip_reg  <= bip_w;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      blank_reg <= 8'h00;
      hold_reg  <= 1'b0;
    end else begin
      if (cal_go) begin
        blank_reg <= BLANK_LOAD;
      end else if (blanking && !wr_reg) begin
        // Count from the setup write so the window covers the device's tick lag
        blank_reg <= blank_reg - 8'h01;
      end
      hold_reg <= cal_go || blanking || (LINK.mode_rb != MODE_NORM);
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      zero_done_reg <= 1'b0;
      order_err_reg <= 1'b0;
      recal_reg     <= 1'b0;
    end else begin
      // A zero step with new settings is the zero step for those settings
      if (cal_go && (mode_w == MODE_SYS_ZERO)) begin
        zero_done_reg <= 1'b1;
      end else if (set_chg) begin
        zero_done_reg <= 1'b0;
      end
      if (bad_ord) begin
        order_err_reg <= 1'b1;
      end else if (stat_wr && AVS_WRITEDATA[STAT_ORDER_BIT]) begin
        order_err_reg <= 1'b0;
      end
      if (set_chg && !cal_go) begin
        recal_reg <= 1'b1;
      end else if (cal_go) begin
        recal_reg <= 1'b0;
      end
    end
  end

  assign AVS_READDATA     = rdata_reg;
  assign CAL_HOLD         = hold_reg;
  assign LINK.setup_wr    = wr_reg;
  assign LINK.cal_mode_hi = mode_reg[1];
  assign LINK.cal_mode_lo = mode_reg[0];
  assign LINK.gain_sel_hi = gain_reg[1];
  assign LINK.gain_sel_lo = gain_reg[0];
  assign LINK.bipolar     = bip_reg;

endmodule
`default_nettype wire

// [bench/acs_assertions.sv]
// Concurrent checks on the link between host controller and sequencer
`timescale 1ns/1ps
`default_nettype none
module acs_assertions (
  input wire logic        CLK_SYS,
  input wire logic        RESETN,
  input wire logic        setup_wr,
  input wire logic        cal_mode_hi,
  input wire logic        cal_mode_lo,
  input wire logic [1:0]  mode_rb,
  input wire logic        result_valid_n,
  input wire logic [15:0] result_data
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);

  wire logic [1:0] wr_mode = {cal_mode_hi, cal_mode_lo};
  logic      [7:0] since_wr;

  // Cycles since the last setup write, saturating; a pending ready raise ends within 130
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      since_wr <= 8'hFF;
    end else if (setup_wr) begin
      since_wr <= 8'h00;
    end else if (since_wr != 8'hFF) begin
      since_wr <= since_wr + 8'h01;
    end
  end

  sequence s_cmd;
    setup_wr && wr_mode != 2'h0;
  endsequence
  sequence s_done;
    (mode_rb != 2'h0 && !setup_wr) ##1 (mode_rb == 2'h0);
  endsequence

  property p_mode_ack;
    setup_wr |=> mode_rb == $past(wr_mode);
  endproperty
  property p_rdy_rise;
    s_cmd |-> ##[0:130] result_valid_n;
  endproperty
  property p_rdy_hold;
    mode_rb != 2'h0 && result_valid_n |=> result_valid_n;
  endproperty
  property p_mode_clears;
    mode_rb != 2'h0 && !setup_wr |=> $stable(mode_rb) || mode_rb == 2'h0;
  endproperty
  property p_fall_normal;
    $fell(result_valid_n) |-> mode_rb == 2'h0;
  endproperty
  property p_coef_gap;
    s_done |-> result_valid_n [*8];
  endproperty
  property p_wr_pulse;
    setup_wr |=> !setup_wr;
  endproperty
  property p_stays_low;
    !result_valid_n && mode_rb == 2'h0 && !setup_wr && since_wr > 8'h82 |=> !result_valid_n;
  endproperty
  property p_data_hold;
    result_valid_n && mode_rb != 2'h0 |=> $stable(result_data);
  endproperty

  a_mode_ack: assert property (p_mode_ack) else $error("mode readback wrong");
  a_rdy_rise: assert property (p_rdy_rise) else $error("ready not raised");
  a_rdy_hold: assert property (p_rdy_hold) else $error("ready fell in cal");
  a_mode_clears: assert property (p_mode_clears) else $error("mode moved");
  a_fall_normal: assert property (p_fall_normal) else $error("ready in cal");
  a_coef_gap: assert property (p_coef_gap) else $error("ready too soon");
  a_wr_pulse: assert property (p_wr_pulse) else $error("setup write long");
  a_stays_low: assert property (p_stays_low) else $error("ready rose");
  a_data_hold: assert property (p_data_hold) else $error("word changed");
endmodule
`default_nettype wire

// [bench/tb_adc_calibration_sequencer.sv]
// Testbench joining host controller and sequencer through the link
`timescale 1ns/1ps
`default_nettype none
module tb_adc_calibration_sequencer import acs_pkg::*;;
  localparam int          PER = 160;
  localparam logic [23:0] ZS  = 24'h10_0000;
  localparam logic [23:0] FS  = 24'h90_0000;
  logic             clk_sys   = 1'b0;
  logic             resetn    = 1'b0;
  logic [3:0]       avs_address = 4'h0;
  logic             avs_read  = 1'b0;
  logic             avs_write = 1'b0;
  logic [31:0]      avs_writedata = 32'h0000_0000;
  logic [31:0]      avs_readdata;
  logic             avs_waitrequest;
  logic             cal_hold;
  logic [RAW_W-1:0] filt_data = 24'h00_0000;
  logic [RAW_W-1:0] analog_input_pair = 24'h00_0000;
  logic             filt_stb  = 1'b0;
  logic [1:0]       input_sel;
  logic [1:0]       pga_gain;
  logic             bipolar;
  logic [RAW_W-1:0] zero_coef;
  logic [RAW_W-1:0] full_coef;
  int               n_errors  = 0;
  int               cmp_count = 0;
  int               nst       = 0;
  int               ph        = 1;

  always #2.5 clk_sys = ~clk_sys;
  acs_link_if link_i ();
  acs_device acs_device_i (.CLK_SYS(clk_sys), .RESETN(resetn), .LINK(link_i.dev),
    .FILT_DATA(filt_data), .FILT_STB(filt_stb), .INPUT_SEL(input_sel), .PGA_GAIN(pga_gain),
    .BIPOLAR(bipolar), .ZERO_COEF(zero_coef), .FULL_COEF(full_coef));
  acs_host acs_host_i (.CLK_SYS(clk_sys), .RESETN(resetn), .AVS_ADDRESS(avs_address),
    .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_BYTEENABLE(4'hF),
    .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(avs_waitrequest), .CAL_HOLD(cal_hold), .LINK(link_i.host));
  acs_assertions acs_assertions_i (.CLK_SYS(clk_sys), .RESETN(resetn),
    .setup_wr(link_i.setup_wr), .cal_mode_hi(link_i.cal_mode_hi),
    .cal_mode_lo(link_i.cal_mode_lo), .mode_rb(link_i.mode_rb),
    .result_valid_n(link_i.result_valid_n), .result_data(link_i.result_data));

  // Output-rate strobe, restarted by each setup write and suppressed in the cycle after it
  always @(posedge clk_sys) begin
    ph <= (link_i.setup_wr || ph == PER) ? 1 : ph + 1;
    filt_stb <= (ph == PER) && !link_i.setup_wr;
    if (ph == PER) begin
      filt_data <= input_sel == SEL_SHORT ? ZS : input_sel == SEL_REF ? FS : analog_input_pair;
    end
    if (filt_stb) begin
      nst <= nst + 1;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic av(input logic [3:0] a, input logic wr, input logic [31:0] d,
                    output logic [31:0] r);
    int n;
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    chk(n < 50, 1'b1, "bus wait");
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  function automatic logic [15:0] exp_out(input logic [23:0] raw, z, f, input logic bip);
    longint sp;
    longint p;
    sp = longint'(f) - longint'(z);
    if (sp <= 0) sp = 1;
    p = (longint'(raw) - longint'(z)) * (64'h0000_0001_0000_0000 / sp);
    p = bip ? 32768 + (p >>> 17) : p >>> 16;
    return p > 65535 ? 16'hFFFF : p < 0 ? 16'h0000 : 16'(p);
  endfunction

  task automatic run_cal(input logic [4:0] ctrl, input int e1, e2, input logic [1:0] esel,
                         input logic [23:0] ez, ef);
    logic [31:0] r;
    logic [3:0]  sel;
    int          n;
    int          b;
    av(REG_CTRL, 1'b1, {27'h000_0000, ctrl}, r);
    av(REG_STATUS, 1'b0, 32'h0000_0000, r);
    chk(r[1:0], ctrl[1:0], "mode");
    chk(r[STAT_BLANK_BIT], 1'b1, "blank");
    chk(r[STAT_READY_BIT], 1'b0, "ready");
    chk(pga_gain, ctrl[3:2], "gain");
    chk(bipolar, ctrl[4], "polarity");
    if (ctrl[1]) chk(cal_hold, 1'b1, "hold");
    b = nst;
    sel = 4'h0;
    for (n = 0; n < 5000 && link_i.mode_rb !== 2'h0; n++) begin
      sel[input_sel] = 1'b1;
      @(negedge clk_sys);
    end
    chk(nst - b, e1, "steps");
    chk(sel[2:1], esel, "input select");
    chk(zero_coef, ez, "zero coef");
    chk(full_coef, ef, "full coef");
    for (n = 0; n < 3000 && link_i.result_valid_n !== 1'b0; n++) @(negedge clk_sys);
    chk(nst - b, e2, "ready periods");
    chk(link_i.result_data, exp_out(analog_input_pair, ez, ef, ctrl[4]), "word");
    av(REG_DATA, 1'b0, 32'h0000_0000, r);
    chk(r, {16'h0000, exp_out(analog_input_pair, ez, ef, ctrl[4])}, "data reg");
  endtask

  task automatic scen_refuse();
    logic [31:0] r;
    av(REG_CTRL, 1'b1, 32'h0000_0003, r);
    av(REG_STATUS, 1'b0, 32'h0000_0000, r);
    chk(r[STAT_ORDER_BIT], 1'b1, "order flag");
    chk(r[1:0], MODE_NORM, "refused mode");
    av(REG_STATUS, 1'b1, 32'h0000_0001 << STAT_ORDER_BIT, r);
    av(REG_CTRL, 1'b1, 32'h0000_0008, r);
    av(REG_STATUS, 1'b0, 32'h0000_0000, r);
    chk(r[STAT_ORDER_BIT], 1'b0, "order clear");
    chk(r[STAT_RECAL_BIT], 1'b1, "recal set");
    av(4'hC, 1'b0, 32'h0000_0000, r);
    chk(r, 32'h0000_0000, "unmapped");
  endtask

  task automatic scen_self();
    logic [31:0] r;
    analog_input_pair = 24'h50_0000;
    run_cal(5'h09, 6, 9, 2'b11, ZS, FS);
    av(REG_STATUS, 1'b0, 32'h0000_0000, r);
    chk(r[STAT_RECAL_BIT], 1'b0, "recal clear");
  endtask

  task automatic scen_sys();
    analog_input_pair = 24'h20_0000;
    run_cal(5'h12, 3, 4, 2'b00, 24'h20_0000, FS);
    analog_input_pair = 24'hA0_0000;
    run_cal(5'h13, 3, 4, 2'b00, 24'h20_0000, 24'hA0_0000);
  endtask

  // Self calibration cut off in its zero step by a system zero command
  task automatic scen_restart();
    logic [31:0] r;
    int          n;
    int          b;
    av(REG_CTRL, 1'b1, 32'h0000_0011, r);
    b = nst;
    for (n = 0; n < 1000 && nst < b + 2; n++) @(negedge clk_sys);
    analog_input_pair = 24'h28_0000;
    run_cal(5'h12, 3, 4, 2'b00, 24'h28_0000, 24'hA0_0000);
  endtask

  initial begin
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    scen_refuse();
    scen_self();
    scen_sys();
    scen_restart();
    finish_test();
  end

  initial begin
    repeat (60000) @(posedge clk_sys);
    n_errors++;
    finish_test();
  end
endmodule
`default_nettype wire
